// ---- sofm_counters.sv ----
// fault error, watchdog error and watchdog refresh counters
// assumes one-cycle event pulses from the watchdog and fault collectors
`timescale 1ns/1ps
`default_nettype none
module sofm_counters (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic count_en_i,
  input wire logic fault_evt_i,
  input wire logic wd_ok_i,
  input wire logic wd_nok_i,
  input wire logic [3:0] wd_refresh_max_i,
  output logic fault_cnt_max_o,
  output logic wd_err_max_o,
  output logic [3:0] fault_cnt_o
);
  typedef struct packed {
    logic [3:0] fault_cnt;
    logic [3:0] wd_err;
    logic [3:0] wd_ref;
  } sofm_cnt_state_type;
  sofm_cnt_state_type st_ff, nxt_st;

  // increment wins over decrement when both arrive together
  always_comb
  begin
    nxt_st = st_ff;
    if (wd_nok_i && st_ff.wd_err != sofm_pkg::wd_err_max)
      nxt_st.wd_err = st_ff.wd_err + 4'h1; // RULE_18
    if (wd_nok_i)
      nxt_st.wd_ref = 4'h0;
    else if (wd_ok_i)
    begin
      if (st_ff.wd_ref + 4'h1 >= wd_refresh_max_i)
      begin
        nxt_st.wd_ref = 4'h0;
        if (st_ff.fault_cnt != 4'h0 && !(count_en_i && fault_evt_i))
          nxt_st.fault_cnt = st_ff.fault_cnt - 4'h1; // RULE_19
      end
      else
        nxt_st.wd_ref = st_ff.wd_ref + 4'h1;
    end
    if (count_en_i && fault_evt_i && st_ff.fault_cnt != sofm_pkg::fault_cnt_max)
      nxt_st.fault_cnt = st_ff.fault_cnt + 4'h1; // RULE_16
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      st_ff <= '{fault_cnt: sofm_pkg::fault_cnt_rst, wd_err: 4'h0, wd_ref: 4'h0};
    else
      st_ff <= nxt_st;
  end

  assign fault_cnt_max_o = st_ff.fault_cnt == sofm_pkg::fault_cnt_max; // RULE_17
  assign wd_err_max_o = st_ff.wd_err == sofm_pkg::wd_err_max;
  assign fault_cnt_o = st_ff.fault_cnt;
endmodule
`default_nettype wire

// ---- sofm_err_mon.sv ----
// error monitor: level fault detect with optional acknowledge window
// assumes the fault pin is already synchronous and held steady by the mcu
`timescale 1ns/1ps
`default_nettype none
module sofm_err_mon (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic active_i,
  input wire logic polarity_i,
  input wire logic [1:0] ack_window_i,
  input wire logic fault_pin_i,
  output logic fault_o
);
  typedef struct packed {
    logic [7:0] ack_cnt;
    logic fault;
  } sofm_em_state_type;
  sofm_em_state_type st_ff, nxt_st;

  // pin equal to polarity is a fault, so polarity zero makes low the fault
  // window counted in units; a steady input is assumed, pulses shorter than the window are not caught
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.fault = 1'b0;
    if (!active_i)
    begin
      nxt_st.ack_cnt = 8'h00; // RULE_02
    end
    else if (fault_pin_i == polarity_i) // RULE_05
    begin
      if (ack_window_i == sofm_pkg::ack_none)
      begin
        nxt_st.fault = 1'b1; // RULE_06
      end
      else if (st_ff.ack_cnt >= 8'(ack_window_i) * 8'(sofm_pkg::ack_unit_cycles))
      begin
        nxt_st.fault = 1'b1;
      end
      else
      begin
        nxt_st.ack_cnt = st_ff.ack_cnt + 8'h01;
      end
    end
    else
    begin
      nxt_st.ack_cnt = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign fault_o = st_ff.fault;
endmodule
`default_nettype wire

// ---- sofm_mcu_model.sv ----
// microcontroller model: reset pin and fault collector output pin
// assumes an external pull-up on the reset wire and pull-down on the fault pin
`timescale 1ns/1ps
`default_nettype none
module sofm_mcu_model (
  input wire logic reset_oe_n_i,
  input wire logic hold_reset_i,
  input wire logic fault_level_i,
  output logic reset_line_o,
  output logic fault_pin_o
);
  // wired-and: either side may pull reset low, the mcu may outlast the device
  assign reset_line_o = reset_oe_n_i & ~hold_reset_i;
  // pin undriven in reset falls to the pull-down, level held steady otherwise
  assign fault_pin_o = reset_line_o ? fault_level_i : 1'h0;
endmodule
`default_nettype wire

// ---- sofm_pkg.sv ----
// package for the safety output fault manager: constants, modes, carriers
// assumes a 100 MHz ref_clk_i; no bus, all configuration arrives on ports
package sofm_pkg;
  localparam int unsigned clk_mhz = 100;
  // stuck-low time of the reset line, in seconds
  localparam int unsigned stuck_time_s = 8;
  localparam longint unsigned stuck_cycles = longint'(stuck_time_s) * clk_mhz * 1000000;
  localparam int unsigned cnt_w = 4;
  localparam logic [3:0] fault_cnt_max = 4'hF;
  localparam logic [3:0] fault_cnt_rst = 4'h0;
  localparam logic [3:0] wd_err_max = 4'hF;
  localparam logic [1:0] ack_none = 2'h0;
  localparam int unsigned ack_unit_cycles = 16;
  localparam logic react_sel_reset = 1'b0;
  localparam logic pol_low_fault = 1'b0;

  typedef enum logic [2:0] {
    sofm_init_type_placeholder = 3'h7
  } sofm_unused_type;

  typedef enum logic [2:0] {
    st_init = 3'h0,
    st_normal = 3'h1,
    st_low_power_on_mode = 3'h2,
    st_low_power_off_mode = 3'h3,
    st_failsafe = 3'h4
  } sofm_mode_type;

  // write-protected initialization configuration
  typedef struct packed {
    logic mon_enable;
    logic mon_polarity;
    logic mon_react_sel;
    logic [1:0] mon_ack_window;
    logic stuck_fs_enable;
    logic [3:0] wd_refresh_max;
  } sofm_cfg_type;

  // wake sources in low-power-on mode
  typedef struct packed {
    logic wake_two;
    logic wake_three;
    logic hv_io;
    logic ldt_expired;
    logic can_pattern;
    logic normal_request;
  } sofm_wake_type;
endpackage

// ---- sofm_props.sv ----
// checker for the safety output fault manager, watching top-level ports only
// assumes one clock domain and the synchronous active-high reset of sofm_top
`timescale 1ns/1ps
`default_nettype none
module sofm_props #(
  parameter longint unsigned stuck_cycles = 50
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire sofm_pkg::sofm_cfg_type cfg_i,
  input wire logic wd_ok_i,
  input wire logic mcu_fault_out_zero_i,
  input wire logic reset_line_i,
  input wire logic limp_release_i,
  input wire logic low_power_on_mode_request_i,
  input wire logic low_power_off_mode_request_i,
  input wire logic reset_safety_output_n_o,
  input wire logic reset_safety_oe_n_o,
  input wire logic limp_safety_output_n_o,
  input wire logic [2:0] mode_o,
  input wire logic init_locked_o
);
  longint unsigned low_ff;
  longint unsigned nxt_low;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // cycles the mcu alone holds the reset wire low while in normal mode
  always_comb
  begin
    nxt_low = (mode_o == 3'h1 && !reset_line_i && reset_safety_oe_n_o) ? low_ff + 1 : 0;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      low_ff <= 0;
    else
      low_ff <= nxt_low;
  end
  sequence s_leave_init;
    mode_o == 3'h0 ##1 mode_o == 3'h1;
  endsequence
  // monitor fault seen in normal mode, routed to limp, no acknowledge time
  sequence s_mon_fault;
    mode_o == 3'h1 && cfg_i.mon_enable && cfg_i.mon_react_sel && cfg_i.mon_ack_window == 2'h0
      && mcu_fault_out_zero_i == cfg_i.mon_polarity && !low_power_on_mode_request_i && !low_power_off_mode_request_i;
  endsequence
  a_drive_value_low: assert property (reset_safety_output_n_o == 1'h0)
    else $error("reset drive value not low");
  a_init_reset_held: assert property (mode_o == 3'h0 |-> !reset_safety_oe_n_o)
    else $error("reset released during init");
  a_failsafe_all_low: assert property (mode_o == 3'h4 |-> !reset_safety_oe_n_o && !limp_safety_output_n_o)
    else $error("safety output released in fail-safe");
  a_low_power_off_mode_pin_state: assert property (mode_o == 3'h3 |-> !reset_safety_oe_n_o && limp_safety_output_n_o)
    else $error("wrong safety outputs in low-power-off");
  a_limp_stays_low: assert property (!limp_safety_output_n_o && !limp_release_i && !low_power_off_mode_request_i
    |=> !limp_safety_output_n_o)
    else $error("limp released without release procedure");
  a_low_power_on_mode_keeps_limp: assert property ($rose(mode_o == 3'h2) |-> $stable(limp_safety_output_n_o))
    else $error("limp changed on low-power-on entry");
  a_lock_after_ok: assert property ($rose(init_locked_o) |-> $past(wd_ok_i))
    else $error("config locked without good refresh");
  a_init_exit_ok: assert property (s_leave_init |-> $past(wd_ok_i) && reset_safety_oe_n_o)
    else $error("normal entered without good refresh or reset release");
  a_mon_fault_limp: assert property (s_mon_fault |-> ##[1:3] !limp_safety_output_n_o)
    else $error("monitor fault did not assert limp");
  a_stuck_failsafe: assert property (low_ff == stuck_cycles + 4 |-> !cfg_i.stuck_fs_enable)
    else $error("stuck reset line did not reach fail-safe");
endmodule
bind sofm_top sofm_props #(.stuck_cycles(stuck_cycles)) u_props (.*);
`default_nettype wire

// ---- sofm_top.sv ----
// safety output fault manager: mode machine and the two safety outputs
// assumes synchronous pins; counters and monitor are the two submodules
// Function
// RULE_01 - monitor enabled only from normal mode
// RULE_02 - monitor off in both low-power modes
// RULE_03 - mcu holds fault pin at steady level
// RULE_04 - monitor reaction goes to reset or limp
// RULE_05 - polarity zero: low level is fault
// RULE_06 - window zero: no acknowledge time
// RULE_07 - software sets pin pull to match polarity
// RULE_08 - reset line bidirectional, mcu may hold low
// RULE_09 - reset stuck low too long: fail-safe
// RULE_10 - limp released by default, sticky until release
// RULE_11 - any configured wake source leaves low-power-on
// RULE_12 - both safety outputs active low
// RULE_13 - reset held from power-up until normal
// RULE_14 - limp asserted only on a fault
// RULE_15 - critical faults always act, others if enabled
// RULE_16 - each fault increments fault error counter; code counts only fault onsets while both outputs are released
// RULE_17 - fault counter at maximum: fail-safe
// RULE_18 - watchdog error counter maximum forces reaction
// RULE_19 - good refresh run decrements fault counter
// RULE_20 - fail-safe keeps all safety outputs asserted
// RULE_21 - low-power-off: reset low, limp released
// RULE_22 - low-power-on keeps previous limp state
// RULE_23 - good refresh closes init, locks configuration
`timescale 1ns/1ps
`default_nettype none
module sofm_top #(
  parameter longint unsigned stuck_cycles = sofm_pkg::stuck_cycles
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire sofm_pkg::sofm_cfg_type cfg_i,
  input wire logic cfg_write_i,
  input wire logic wd_ok_i,
  input wire logic wd_nok_i,
  input wire logic mcu_fault_out_zero_i,
  input wire logic reset_line_i,
  input wire logic critical_fault_i,
  input wire logic config_fault_i,
  input wire logic config_fault_rst_en_i,
  input wire logic config_fault_limp_en_i,
  input wire logic limp_release_i,
  input wire logic low_power_on_mode_request_i,
  input wire logic low_power_off_mode_request_i,
  input wire sofm_pkg::sofm_wake_type wake_i,
  input wire sofm_pkg::sofm_wake_type wake_en_i,
  output logic reset_safety_output_n_o,
  output logic reset_safety_oe_n_o,
  output logic limp_safety_output_n_o,
  output logic [2:0] mode_o,
  output logic init_locked_o,
  output logic [3:0] fault_cnt_o
);
  typedef struct packed {
    sofm_pkg::sofm_mode_type mode;
    sofm_pkg::sofm_cfg_type cfg;
    logic locked;
    logic rst_assert;
    logic limp_assert;
    logic [39:0] stuck_cnt;
    logic [3:0] fault_cnt;
    logic fault_seen;
  } sofm_top_state_type;
  sofm_top_state_type st_ff, nxt_st;

  logic mon_active;
  logic mon_fault;
  logic cnt_fault_max;
  logic wd_err_max;
  logic [3:0] fault_cnt;
  logic fault_evt;
  logic fault_any;
  logic react_rst;
  logic react_limp;
  logic stuck_expired;
  logic wake_hit;

  assign mon_active = st_ff.mode == sofm_pkg::st_normal && st_ff.cfg.mon_enable; // RULE_01

  sofm_err_mon u_mon (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .active_i(mon_active),
    .polarity_i(st_ff.cfg.mon_polarity),
    .ack_window_i(st_ff.cfg.mon_ack_window),
    .fault_pin_i(mcu_fault_out_zero_i),
    .fault_o(mon_fault)
  );

  // only fresh faults while outputs are released feed the counter
  // a level fault counts once at its onset, not on every cycle it stands
  assign fault_any = mon_fault || critical_fault_i || config_fault_i;
  assign fault_evt = fault_any && !st_ff.fault_seen; // RULE_16

  sofm_counters u_cnt (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .count_en_i(!st_ff.rst_assert && !st_ff.limp_assert), // RULE_16
    .fault_evt_i(fault_evt),
    .wd_ok_i(wd_ok_i && st_ff.locked),
    .wd_nok_i(wd_nok_i && st_ff.locked),
    .wd_refresh_max_i(st_ff.cfg.wd_refresh_max),
    .fault_cnt_max_o(cnt_fault_max),
    .wd_err_max_o(wd_err_max),
    .fault_cnt_o(fault_cnt)
  );

  // reaction routing of each fault source onto the two outputs
  always_comb
  begin
    react_rst = critical_fault_i || wd_err_max; // RULE_15 RULE_18
    react_limp = critical_fault_i || wd_err_max;
    if (config_fault_i && config_fault_rst_en_i)
      react_rst = 1'b1; // RULE_15
    if (config_fault_i && config_fault_limp_en_i)
      react_limp = 1'b1;
    if (mon_fault && st_ff.cfg.mon_react_sel == sofm_pkg::react_sel_reset)
      react_rst = 1'b1; // RULE_04
    if (mon_fault && st_ff.cfg.mon_react_sel != sofm_pkg::react_sel_reset)
      react_limp = 1'b1; // RULE_04
  end

  // line read back low while released counts as held by the mcu
  assign stuck_expired = st_ff.stuck_cnt >= 40'(stuck_cycles); // RULE_09
  assign wake_hit = |(wake_i & wake_en_i); // RULE_11

  always_comb
  begin
    nxt_st = st_ff;
    // own assertion of the line never counts toward the stuck time
    if (!reset_line_i && !st_ff.rst_assert)
    begin
      if (!stuck_expired)
        nxt_st.stuck_cnt = st_ff.stuck_cnt + 40'h1; // RULE_08
    end
    else
      nxt_st.stuck_cnt = 40'h0;
    unique case (st_ff.mode)
      sofm_pkg::st_init:
      begin
        if (cfg_write_i && !st_ff.locked)
          nxt_st.cfg = cfg_i;
        if (wd_ok_i)
        begin
          nxt_st.locked = 1'b1; // RULE_23
          nxt_st.mode = sofm_pkg::st_normal;
          nxt_st.rst_assert = 1'b0; // RULE_13
        end
      end
      sofm_pkg::st_normal:
      begin
        if (react_rst)
          nxt_st.rst_assert = 1'b1;
        if (react_limp)
          nxt_st.limp_assert = 1'b1; // RULE_14
        else if (limp_release_i)
          nxt_st.limp_assert = 1'b0; // RULE_10
        if (react_rst == 1'b0 && st_ff.rst_assert && reset_line_i == 1'b0 && 1'b0)
          nxt_st.rst_assert = 1'b0;
        if (st_ff.rst_assert && !react_rst && wd_ok_i)
          nxt_st.rst_assert = 1'b0;
        if (low_power_off_mode_request_i)
        begin
          nxt_st.mode = sofm_pkg::st_low_power_off_mode; // RULE_02
          nxt_st.rst_assert = 1'b1; // RULE_21
          nxt_st.limp_assert = 1'b0;
        end
        else if (low_power_on_mode_request_i)
          nxt_st.mode = sofm_pkg::st_low_power_on_mode; // RULE_22
      end
      sofm_pkg::st_low_power_on_mode:
      begin
        if (wake_hit)
          nxt_st.mode = sofm_pkg::st_normal; // RULE_11
      end
      sofm_pkg::st_low_power_off_mode:
      begin
        nxt_st.rst_assert = 1'b1; // RULE_21
        nxt_st.limp_assert = 1'b0;
        if (wake_hit)
          nxt_st.mode = sofm_pkg::st_normal;
      end
      sofm_pkg::st_failsafe:
      begin
        nxt_st.rst_assert = 1'b1; // RULE_20
        nxt_st.limp_assert = 1'b1;
      end
      default:
        nxt_st.mode = sofm_pkg::st_failsafe;
    endcase
    // fail-safe takes priority over every other mode move
    if (cnt_fault_max || (stuck_expired && st_ff.cfg.stuck_fs_enable))
    begin
      nxt_st.mode = sofm_pkg::st_failsafe; // RULE_17 RULE_09
      nxt_st.rst_assert = 1'b1; // RULE_20
      nxt_st.limp_assert = 1'b1;
    end
    nxt_st.fault_cnt = fault_cnt;
    nxt_st.fault_seen = fault_any;
  end

  // reset held asserted from power-up, limp released
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '0;
      st_ff.mode <= sofm_pkg::st_init;
      st_ff.rst_assert <= 1'b1; // RULE_13
      st_ff.limp_assert <= 1'b0; // RULE_10
    end
    else
      st_ff <= nxt_st;
  end

  // outputs are low when asserted; open-drain enable low while driving
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      reset_safety_output_n_o <= 1'b0;
      reset_safety_oe_n_o <= 1'b0;
      limp_safety_output_n_o <= 1'b1;
      mode_o <= 3'h0;
      init_locked_o <= 1'b0;
      fault_cnt_o <= 4'h0;
    end
    else
    begin
      reset_safety_output_n_o <= 1'b0; // RULE_12
      reset_safety_oe_n_o <= ~nxt_st.rst_assert; // RULE_08
      limp_safety_output_n_o <= ~nxt_st.limp_assert; // RULE_12
      mode_o <= nxt_st.mode;
      init_locked_o <= nxt_st.locked;
      fault_cnt_o <= fault_cnt;
    end
  end
endmodule
`default_nettype wire

// ---- sofm_top_tb.sv ----
// testbench for sofm_top with the mcu model on the far side
// assumes a 100 MHz clock and a shortened stuck-reset count
`timescale 1ns/1ps
`default_nettype none
module sofm_top_tb;
  localparam longint unsigned stuck = 50;
  logic ref_clk_i = 0, sys_rst_i = 1, cfg_write_i = 0, wd_ok_i = 0, wd_nok_i = 0;
  logic critical_fault_i = 0, config_fault_i = 0, limp_release_i = 0;
  logic low_power_on_mode_request_i = 0, low_power_off_mode_request_i = 0, hold = 0, flvl = 1;
  logic reset_line_i, mcu_fault_out_zero_i, oe_n, drv_n, limp, locked;
  logic [2:0] mode;
  logic [3:0] fcnt;
  // monitor on, low level faults, limp reaction, no ack time, stuck check on
  sofm_pkg::sofm_cfg_type cfg_i = '{1'h1, 1'h0, 1'h1, 2'h0, 1'h1, 4'h3};
  sofm_pkg::sofm_wake_type wake_i = '0, wake_en_i = '1;
  int error_cnt = 0, tests_run = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  sofm_top #(.stuck_cycles(stuck)) DUT (.ref_clk_i, .sys_rst_i, .cfg_i, .cfg_write_i,
    .wd_ok_i, .wd_nok_i, .mcu_fault_out_zero_i, .reset_line_i, .critical_fault_i,
    .config_fault_i, .config_fault_rst_en_i(1'h0), .config_fault_limp_en_i(1'h0),
    .limp_release_i, .low_power_on_mode_request_i, .low_power_off_mode_request_i, .wake_i, .wake_en_i,
    .reset_safety_output_n_o(drv_n), .reset_safety_oe_n_o(oe_n),
    .limp_safety_output_n_o(limp), .mode_o(mode), .init_locked_o(locked), .fault_cnt_o(fcnt));
  sofm_mcu_model mcu (.reset_oe_n_i(oe_n), .hold_reset_i(hold), .fault_level_i(flvl),
    .reset_line_o(reset_line_i), .fault_pin_o(mcu_fault_out_zero_i));
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // inputs only move at the falling edge
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // reset, configure, close init; the fault pin reads faulty only while reset is held
  task automatic t_init;
    sys_rst_i = 1;
    tick(5);
    sys_rst_i = 0;
    chk("oe_n", 4'h0, 4'(oe_n));
    chk("limp", 4'h1, 4'(limp));
    chk("drv", 4'h0, 4'(drv_n));
    chk("lock", 4'h0, 4'(locked));
    pulse(cfg_write_i);
    pulse(wd_ok_i);
    chk("mode", 4'h1, 4'(mode));
    chk("oe_n", 4'h1, 4'(oe_n));
    chk("lock", 4'h1, 4'(locked));
    tick(3);
    chk("limp", 4'h1, 4'(limp));
  endtask
  // monitor fault, sticky limp, low-power-on with every wake source
  task automatic t_run;
    flvl = 0;
    tick(2);
    chk("limp", 4'h0, 4'(limp));
    chk("oe_n", 4'h1, 4'(oe_n));
    tick(2);
    chk("fcnt", 4'h1, fcnt);
    pulse(limp_release_i);
    tick(1);
    chk("limp", 4'h0, 4'(limp));
    for (int i = 0; i < 6; i++)
    begin
      pulse(low_power_on_mode_request_i);
      chk("mode", 4'h2, 4'(mode));
      chk("limp", 4'h0, 4'(limp));
      flvl = 1;
      wake_i = sofm_pkg::sofm_wake_type'(6'h20 >> i);
      tick(1);
      wake_i = '0;
      chk("mode", 4'h1, 4'(mode));
      tick(1);
    end
    pulse(limp_release_i);
    tick(1);
    chk("limp", 4'h1, 4'(limp));
    config_fault_i = 1;
    tick(3);
    chk("cfgflt", 4'h3, {2'h0, oe_n, limp});
    chk("fcnt", 4'h2, fcnt);
    config_fault_i = 0;
    critical_fault_i = 1;
    tick(3);
    chk("crit", 4'h0, 4'(oe_n & limp));
    critical_fault_i = 0;
    pulse(low_power_off_mode_request_i);
    chk("mode", 4'h3, 4'(mode));
    chk("pins", 4'h1, {2'h0, oe_n, limp});
  endtask
  // mcu keeps reset low past the stuck time
  task automatic t_stuck;
    hold = 1;
    tick(int'(stuck) + 6);
    chk("mode", 4'h4, 4'(mode));
    chk("pins", 4'h0, {2'h0, oe_n, limp});
    hold = 0;
  endtask
  // one fault, then a run of three good refreshes takes it back off
  task automatic t_refresh;
    config_fault_i = 1;
    tick(2);
    config_fault_i = 0;
    tick(2);
    chk("fcnt", 4'h1, fcnt);
    repeat (3)
    begin
      pulse(wd_ok_i);
      tick(1);
    end
    tick(2);
    chk("fcnt", 4'h0, fcnt);
    chk("pins", 4'h3, {2'h0, oe_n, limp});
  endtask
  // watchdog error counter driven to its maximum
  task automatic t_wd;
    repeat (15)
    begin
      pulse(wd_nok_i);
      tick(1);
    end
    tick(2);
    chk("wderr", 4'h0, 4'(oe_n & limp));
  endtask
  initial
  begin
    t_init;
    t_run;
    t_init;
    t_stuck;
    t_init;
    t_refresh;
    t_wd;
    print_verdict;
  end
  // whole run is under two hundred cycles
  initial
  begin
    #20us;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
